// *** src/dtemap_top.sv ***
// dte port to t1 timeslot mapper with axi4-lite control
`default_nettype none
module dtemap_top import dtemap_pkg::*; #(
  parameter longint IDLE_CYCLES = DTEMAP_IDLE_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // t1 frame side, on the link clock
  input wire logic link_clk_in,
  input wire logic frame_start_in,
  input wire logic rx_line_bit_in,
  output logic tx_line_bit_out,
  // dte side
  input wire logic dte_tx_data_in,
  input wire logic dte_ext_clk_in,
  output logic dte_rx_data_out,
  output logic dte_tx_enable_out,
  input wire logic rts_in,
  output logic cts_out,
  output logic dcd_out,
  output logic dsr_out,
  // device conditions
  input wire logic v54_loop_in,
  input wire logic prbs511_test_in,
  input wire logic self_test_in,
  input wire logic network_test_in,
  input wire logic network_alarm_in,
  input wire logic network_signal_ok_in,
  input wire logic remote_cmd_in,
  output logic [16:0] port_rate_kbps_out,
  output logic inband_open_out,
  output logic mgmt_tx_bit_out,
  output logic mgmt_rx_bit_out
);
  logic [31:0] ctrl_q;
  logic [31:0] slot_q;
  logic [15:0] mgmt_tx_q;
  logic aw_q;
  logic w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] bresp_q;
  logic [1:0] rresp_q;

  // write address and data taken in either order
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
      end
      if (aw_q && w_q) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
      end
    end
  end
  assign s_axi_awready_out = !aw_q && !bvalid_q;
  assign s_axi_wready_out = !w_q && !bvalid_q;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // register write and write response
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ctrl_q <= DTEMAP_CTRL_RST;
      slot_q <= DTEMAP_SLOT_RST;
      mgmt_tx_q <= 16'h0000;
      bvalid_q <= 1'b0;
      bresp_q <= DTEMAP_RESP_OK;
    end else begin
      if (aw_q && w_q) begin
        bvalid_q <= 1'b1;
        bresp_q <= DTEMAP_RESP_OK;
        case (awaddr_q)
          DTEMAP_A_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
          DTEMAP_A_SLOT: slot_q <= merge(slot_q, wdata_q, wstrb_q);
          DTEMAP_A_MGMT: mgmt_tx_q <= 16'(merge({16'h0000, mgmt_tx_q}, wdata_q, wstrb_q));
          DTEMAP_A_STAT: bresp_q <= DTEMAP_RESP_OK;
          default: bresp_q <= DTEMAP_RESP_ERR;
        endcase
      end else if (s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;

  // decoded configuration
  logic base64;
  logic alt_req;
  dtemap_clk_t clk_sel;
  logic invert;
  dtemap_ib_t ib_mode;
  logic [4:0] first_raw;
  logic [4:0] count_raw;
  logic [4:0] first_slot;
  logic [4:0] slot_count;
  logic alt_eff;
  assign base64 = ctrl_q[DTEMAP_C_BASE64];
  assign alt_req = ctrl_q[DTEMAP_C_ALT];
  assign clk_sel = dtemap_clk_t'(ctrl_q[DTEMAP_C_CLK +: 2]);
  assign invert = ctrl_q[DTEMAP_C_INV];
  assign ib_mode = dtemap_ib_t'(ctrl_q[DTEMAP_C_IB +: 2]);
  assign first_raw = slot_q[4:0];
  assign count_raw = slot_q[12:8];

  // clamp first slot into 1..24 and count into 0..24
  always_comb begin
    first_slot = first_raw;
    if (first_slot == 5'd0) first_slot = 5'd1;
    if (first_slot > 5'(DTEMAP_SLOTS)) first_slot = 5'(DTEMAP_SLOTS);
    slot_count = count_raw;
    if (slot_count > 5'(DTEMAP_SLOTS)) slot_count = 5'(DTEMAP_SLOTS);
    alt_eff = alt_req && (slot_count <= 5'(DTEMAP_ALT_MAX));
    // six bits so the last-slot sum cannot wrap past 31
    if (alt_eff) begin
      if ({1'b0, first_slot} + 6'((slot_count - 5'd1) * 2) > 6'(DTEMAP_SLOTS)) begin
        slot_count = 5'((DTEMAP_SLOTS - first_slot) / 2 + 1);
      end
    end else if ({1'b0, first_slot} + {1'b0, slot_count} - 6'd1 > 6'(DTEMAP_SLOTS)) begin
      slot_count = 5'(DTEMAP_SLOTS + 1) - first_slot;
    end
  end

  // occupancy map of the frame
  logic [DTEMAP_SLOTS-1:0] slot_map;
  always_comb begin
    slot_map = '0;
    for (int s = 1; s <= DTEMAP_SLOTS; s++) begin
      if (s >= first_slot) begin
        if (alt_eff ? (((s - first_slot) % 2 == 0) && ((s - first_slot) / 2 < slot_count))
                    : (s - first_slot < slot_count)) begin
          slot_map[s-1] = 1'b1;
        end
      end
    end
  end

  // automatic in-band channel idle timer
  logic [2:0] rcmd_sync_q;
  logic [39:0] idle_q;
  logic ib_auto_open_q;
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rcmd_sync_q <= 3'b000;
      idle_q <= 40'h00_0000_0000;
      ib_auto_open_q <= 1'b0;
    end else begin
      rcmd_sync_q <= {rcmd_sync_q[1:0], remote_cmd_in};
      if (rcmd_sync_q[1] && !rcmd_sync_q[2]) begin
        ib_auto_open_q <= 1'b1;
        idle_q <= 40'h00_0000_0000;
      end else if (ib_auto_open_q) begin
        if (idle_q >= 40'(IDLE_CYCLES - 1)) begin
          ib_auto_open_q <= 1'b0;
        end else begin
          idle_q <= idle_q + 40'h00_0000_0001;
        end
      end
    end
  end
  logic ib_open;
  assign ib_open = (ib_mode == DTEMAP_IB_ON) ||
                   ((ib_mode == DTEMAP_IB_AUTO) && ib_auto_open_q);
  assign inband_open_out = ib_open;

  // port rate in kbps
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      port_rate_kbps_out <= 17'h0_0000;
    end else begin
      port_rate_kbps_out <= 17'(slot_count * (base64 ? 64 : 56))
                            - ((ib_open && base64 && slot_count != 0) ? 17'd8 : 17'd0);
    end
  end

  // synchronised condition inputs
  logic [7:0] cond_s1_q;
  logic [7:0] cond_q;
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cond_s1_q <= 8'h00;
      cond_q <= 8'h00;
    end else begin
      cond_s1_q <= {rts_in, v54_loop_in, prbs511_test_in, self_test_in, network_test_in,
                    network_alarm_in, network_signal_ok_in, 1'b0};
      cond_q <= cond_s1_q;
    end
  end
  logic no_ds0;
  assign no_ds0 = (slot_count == 5'd0);

  // modem control outputs
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cts_out <= 1'b0;
      dcd_out <= 1'b0;
      dsr_out <= 1'b0;
    end else begin
      cts_out <= ctrl_q[DTEMAP_C_FCTS] || (cond_q[7] && !(cond_q[6] || cond_q[5] || cond_q[4] ||
                 cond_q[3] || no_ds0 || cond_q[2]));
      dcd_out <= ctrl_q[DTEMAP_C_FDCD] ||
                 (cond_q[1] && !(cond_q[4] || no_ds0 || cond_q[2]));
      dsr_out <= ctrl_q[DTEMAP_C_FDSR] || !(cond_q[6] || cond_q[5] || cond_q[4]);
    end
  end

  // configuration crossed to the link domain (static while running)
  logic [DTEMAP_SLOTS-1:0] map_l1_q, map_l2_q;
  logic [4:0] first_l1_q, first_l2_q;
  logic [3:0] cfg_l1_q, cfg_l2_q;
  logic [15:0] mtx_l1_q, mtx_l2_q;
  always_ff @(posedge link_clk_in) begin
    map_l1_q <= slot_map;
    map_l2_q <= map_l1_q;
    first_l1_q <= first_slot;
    first_l2_q <= first_l1_q;
    cfg_l1_q <= {ib_open, base64, invert, 1'b0};
    cfg_l2_q <= cfg_l1_q;
    mtx_l1_q <= mgmt_tx_q;
    mtx_l2_q <= mtx_l1_q;
  end

  // system reset carried into the link domain through two flops
  logic lrst_s1_q, lrst_s2_q;
  always_ff @(posedge link_clk_in) begin
    lrst_s1_q <= resetn_in;
    lrst_s2_q <= lrst_s1_q;
  end

  // sampling clock phase: auto compares both phases of the dte data
  logic tx_rise_q, tx_fall_q, tx_rise2_q, tx_fall2_q, ext_s1_q, ext_s2_q, ext_s3_q;
  logic tx_ext_q, auto_inv_q;
  logic [3:0] mism_q;
  always_ff @(posedge link_clk_in) begin
    tx_rise_q <= dte_tx_data_in;
    tx_rise2_q <= tx_rise_q;
    ext_s1_q <= dte_ext_clk_in;
    ext_s2_q <= ext_s1_q;
    ext_s3_q <= ext_s2_q;
    if (ext_s2_q && !ext_s3_q) tx_ext_q <= tx_rise2_q;
    // data changing near our edge shows as rise/fall disagreement
    if (tx_rise2_q != tx_fall2_q) mism_q <= mism_q + 4'h1;
    if (&mism_q) begin
      auto_inv_q <= !auto_inv_q;
      mism_q <= 4'h0;
    end
    // start from the normal phase with a clear count
    if (!lrst_s2_q) begin
      auto_inv_q <= 1'b0;
      mism_q <= 4'h0;
      tx_ext_q <= 1'b0;
    end
  end
  always_ff @(negedge link_clk_in) begin
    tx_fall_q <= dte_tx_data_in;
    tx_fall2_q <= tx_fall_q;
  end
  logic [1:0] csel_l1_q, csel_l2_q;
  always_ff @(posedge link_clk_in) begin
    csel_l1_q <= ctrl_q[DTEMAP_C_CLK +: 2];
    csel_l2_q <= csel_l1_q;
  end
  logic tx_sample;
  always_comb begin
    case (dtemap_clk_t'(csel_l2_q))
      DTEMAP_CLK_INT: tx_sample = tx_rise2_q;
      DTEMAP_CLK_INV: tx_sample = tx_fall2_q;
      DTEMAP_CLK_EXT: tx_sample = tx_ext_q;
      DTEMAP_CLK_AUTO: tx_sample = auto_inv_q ? tx_fall2_q : tx_rise2_q;
      default: tx_sample = tx_rise2_q;
    endcase
  end

  // frame position and slot mux
  logic [4:0] slot_q_l;
  logic [2:0] bit_q_l;
  logic [15:0] mrx_q_l;
  logic [3:0] mptr_q_l;
  always_ff @(posedge link_clk_in) begin
    if (frame_start_in) begin
      slot_q_l <= 5'd1;
      bit_q_l <= 3'd0;
    end else begin
      bit_q_l <= bit_q_l + 3'd1;
      if (bit_q_l == 3'(DTEMAP_BITS_PER_SLOT - 1)) slot_q_l <= slot_q_l + 5'd1;
    end
  end
  logic in_slot, ib_bit, base_bit;
  assign in_slot = (slot_q_l >= 5'd1) && (slot_q_l <= 5'(DTEMAP_SLOTS)) &&
                   map_l2_q[slot_q_l - 5'd1];
  assign base_bit = !cfg_l2_q[2] && (bit_q_l == 3'(DTEMAP_BITS_PER_SLOT - 1)); // 56k lsb
  assign ib_bit = cfg_l2_q[3] && (slot_q_l == first_l2_q) &&
                  (bit_q_l == 3'(DTEMAP_BITS_PER_SLOT - 1));
  always_ff @(posedge link_clk_in) begin
    dte_tx_enable_out <= in_slot && !base_bit && !ib_bit;
    if (in_slot && ib_bit) begin
      tx_line_bit_out <= mtx_l2_q[mptr_q_l];
      mrx_q_l[mptr_q_l] <= rx_line_bit_in;
      mptr_q_l <= mptr_q_l + 4'h1;
    end else if (in_slot && !base_bit) begin
      tx_line_bit_out <= tx_sample ^ cfg_l2_q[1];
      dte_rx_data_out <= rx_line_bit_in ^ cfg_l2_q[1];
    end else begin
      tx_line_bit_out <= 1'b1;
    end
    // management word pointer starts at bit 0
    if (!lrst_s2_q) mptr_q_l <= 4'h0;
  end
  assign mgmt_tx_bit_out = mtx_l2_q[mptr_q_l];
  assign mgmt_rx_bit_out = mrx_q_l[mptr_q_l];

  // read path
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= DTEMAP_RESP_OK;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_q <= 1'b1;
      rresp_q <= DTEMAP_RESP_OK;
      case (s_axi_araddr_in)
        DTEMAP_A_CTRL: rdata_q <= ctrl_q;
        DTEMAP_A_SLOT: rdata_q <= slot_q;
        DTEMAP_A_STAT: rdata_q <= {8'h00, slot_count, 1'b0, alt_eff, ib_open,
                                   port_rate_kbps_out[15:0]};
        DTEMAP_A_MGMT: rdata_q <= {16'h0000, mgmt_tx_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= DTEMAP_RESP_ERR;
        end
      endcase
    end else if (s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;
endmodule : dtemap_top
`default_nettype wire

// *** pkg/dtemap_pkg.sv ***
// constants and types for the dte port channel mapper
`default_nettype none
package dtemap_pkg;
  localparam int DTEMAP_SLOTS = 24;
  localparam int DTEMAP_ALT_MAX = 12;
  localparam int DTEMAP_BITS_PER_SLOT = 8;
  localparam int DTEMAP_CLK_HZ = 25_000_000;
  localparam int DTEMAP_IDLE_MIN = 10;
  localparam longint DTEMAP_IDLE_CYC = longint'(DTEMAP_IDLE_MIN) * 60 * DTEMAP_CLK_HZ;
  // register byte addresses
  localparam logic [7:0] DTEMAP_A_CTRL = 8'h00;
  localparam logic [7:0] DTEMAP_A_SLOT = 8'h04;
  localparam logic [7:0] DTEMAP_A_STAT = 8'h08;
  localparam logic [7:0] DTEMAP_A_MGMT = 8'h0c;
  // ctrl field positions
  localparam int DTEMAP_C_BASE64 = 0;
  localparam int DTEMAP_C_ALT = 1;
  localparam int DTEMAP_C_CLK = 2;
  localparam int DTEMAP_C_INV = 4;
  localparam int DTEMAP_C_FCTS = 5;
  localparam int DTEMAP_C_FDCD = 6;
  localparam int DTEMAP_C_FDSR = 7;
  localparam int DTEMAP_C_IB = 8;
  localparam logic [31:0] DTEMAP_CTRL_RST = 32'h0000_000d;
  localparam logic [31:0] DTEMAP_SLOT_RST = 32'h0000_0101;
  localparam logic [1:0] DTEMAP_RESP_OK = 2'b00;
  localparam logic [1:0] DTEMAP_RESP_ERR = 2'b10;
  typedef enum logic [1:0] {
    DTEMAP_CLK_INT = 2'b00,
    DTEMAP_CLK_INV = 2'b01,
    DTEMAP_CLK_EXT = 2'b10,
    DTEMAP_CLK_AUTO = 2'b11
  } dtemap_clk_t;
  typedef enum logic [1:0] {
    DTEMAP_IB_OFF = 2'b00,
    DTEMAP_IB_ON = 2'b01,
    DTEMAP_IB_AUTO = 2'b10
  } dtemap_ib_t;
endpackage : dtemap_pkg
`default_nettype wire

// *** verification/dtemap_assertions.sv ***
// concurrent checks on the mapper's modem controls and bus handshakes
`default_nettype none
module dtemap_assertions import dtemap_pkg::*; (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic rts_in,
  input wire logic v54_loop_in,
  input wire logic self_test_in,
  input wire logic network_signal_ok_in,
  input wire logic cts_out,
  input wire logic dcd_out,
  input wire logic dsr_out
);
  logic [7:0] adr_q;
  logic [7:0] wd_q;
  logic [7:0] frc_q;
  logic wip;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  // a write is open from request to response, force bits are in flux then
  assign wip = s_axi_awvalid_in || s_axi_wvalid_in || s_axi_bvalid_out;

  // capture the beats of the write under way
  always_ff @(posedge clk_in) begin
    if (s_axi_awvalid_in && s_axi_awready_out) adr_q <= s_axi_awaddr_in;
    if (s_axi_wvalid_in && s_axi_wready_out)
      wd_q <= s_axi_wstrb_in[0] ? s_axi_wdata_in[7:0] : frc_q;
  end

  // mirror of the force bits, updated when the response is accepted
  always_ff @(posedge clk_in) begin
    if (!resetn_in) frc_q <= 8'h00;
    else if (s_axi_bvalid_out && s_axi_bready_in && s_axi_bresp_out == DTEMAP_RESP_OK
             && adr_q == DTEMAP_A_CTRL) frc_q <= wd_q;
  end

  property p_cts_rts;
    (!rts_in && !frc_q[5] && !wip) [*5] |-> !cts_out;
  endproperty
  a_cts_rts: assert property (p_cts_rts) else $error("cts on without rts");
  property p_cts_loop;
    (v54_loop_in && !frc_q[5] && !wip) [*5] |-> !cts_out;
  endproperty
  a_cts_loop: assert property (p_cts_loop) else $error("cts on in loopback");
  property p_dcd_sig;
    (!network_signal_ok_in && !frc_q[6] && !wip) [*5] |-> !dcd_out;
  endproperty
  a_dcd_sig: assert property (p_dcd_sig) else $error("dcd on without signal");
  property p_dsr_self;
    (self_test_in && !frc_q[7] && !wip) [*5] |-> !dsr_out;
  endproperty
  a_dsr_self: assert property (p_dsr_self) else $error("dsr on in self test");
  property p_force;
    ((|frc_q[7:5]) && !wip) [*3] |-> ({dsr_out, dcd_out, cts_out} & frc_q[7:5]) == frc_q[7:5];
  endproperty
  a_force: assert property (p_force) else $error("forced output not on");
  property p_r_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_r_lat;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_b_refuse;
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
  endproperty
  a_b_refuse: assert property (p_b_refuse) else $error("write taken during response");
endmodule : dtemap_assertions
`default_nettype wire

// *** verification/dtemap_dte_model.sv ***
// behavioural dte: clocks out a byte pattern when the mapper asks for bits
`default_nettype none
module dtemap_dte_model (
  input wire logic link_clk_in,
  input wire logic tx_enable_in,
  input wire logic [7:0] pattern_in,
  output logic data_out,
  output logic ext_clk_out
);
  logic [2:0] idx = 3'h0;

  // supplied clock runs only for requested bits, still otherwise
  assign ext_clk_out = tx_enable_in & ~link_clk_in;

  // next bit per request, a toggling line between requests
  initial data_out = 1'b0;
  always @(posedge link_clk_in) begin
    if (tx_enable_in) begin
      data_out <= pattern_in[idx];
      idx <= idx + 3'h1;
    end else begin
      data_out <= ~data_out;
    end
  end
endmodule : dtemap_dte_model
`default_nettype wire

// *** verification/dtemap_top_test.sv ***
// self-checking bench for the dte port mapper
`default_nettype none
module dtemap_top_test import dtemap_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int IDLE = 100;
  logic clk_in = 1'b0;
  logic link_clk_in = 1'b0;
  logic resetn_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
  logic s_axi_rready_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_arready_out, s_axi_rvalid_out, rx_line_bit_in, tx_line_bit_out;
  logic dte_tx_data_in, dte_ext_clk_in, dte_rx_data_out, dte_tx_enable_out, rts_in, cts_out;
  logic dcd_out, dsr_out, v54_loop_in, prbs511_test_in, self_test_in, network_test_in;
  logic network_alarm_in, network_signal_ok_in, remote_cmd_in, inband_open_out;
  logic mgmt_tx_bit_out, mgmt_rx_bit_out;
  logic frame_start_in = 1'b0;
  logic [7:0] fcnt = 8'h00;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, d;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
  logic [16:0] port_rate_kbps_out;
  logic [15:0] seed;
  logic [6:0] cv;
  logic [2:0] fv;
  int fails, checks_done, i;
  int tf[8] = '{1, 24, 1, 1, 20, 2, 14, 1};
  int tn[8] = '{24, 1, 12, 13, 8, 2, 6, 1};
  logic [31:0] tc[8] = '{32'h1, 32'h0, 32'h3, 32'h3, 32'h1, 32'h101, 32'h2, 32'h100};

  // clocks, the link clock unrelated in phase
  always #20 clk_in = ~clk_in;
  initial #7 forever #6 link_clk_in = ~link_clk_in;

  // frame marker every 193 link bits, line looped back
  always @(posedge link_clk_in) begin
    fcnt <= (fcnt == 8'hc0) ? 8'h00 : fcnt + 8'h01;
    frame_start_in <= (fcnt == 8'hc0);
  end
  assign rx_line_bit_in = tx_line_bit_out;

  dtemap_top #(.IDLE_CYCLES(IDLE)) u_dut (.*);
  dtemap_dte_model u_dte (.link_clk_in(link_clk_in), .tx_enable_in(dte_tx_enable_out),
    .pattern_in(8'ha5), .data_out(dte_tx_data_in), .ext_clk_out(dte_ext_clk_in));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // status word: clamped count, effective placement, inband, rate
  function automatic logic [31:0] stat_exp(input int f, input int n, input logic [31:0] c);
    int k, lim, rt;
    logic a, ib;
    a = c[DTEMAP_C_ALT] && n <= DTEMAP_ALT_MAX;
    ib = c[9:8] == DTEMAP_IB_ON;
    lim = a ? (DTEMAP_SLOTS - f) / 2 + 1 : DTEMAP_SLOTS + 1 - f;
    k = n < lim ? n : lim;
    rt = k * (c[DTEMAP_C_BASE64] ? 64 : 56) - ((ib && c[DTEMAP_C_BASE64]) ? 8 : 0);
    return {8'h00, k[4:0], 1'b0, a, ib, rt[15:0]};
  endfunction : stat_exp

  // {dsr, dcd, cts} from {rts, loop, 511, self, net test, alarm, signal ok}
  function automatic logic [2:0] ctl_exp(input logic [6:0] v, input logic [2:0] f);
    return f | {!(v[5] || v[4] || v[3]), v[0] && !v[3] && !v[1], v[6] && v[5:1] == 5'h00};
  endfunction : ctl_exp

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= v;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      if (s_axi_bvalid_out) begin
        s_axi_bready_in <= 1'b0;
        check({30'h0, s_axi_bresp_out}, {30'h0, DTEMAP_RESP_OK});
        return;
      end
    end
    fails++;
    wrap_up();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      if (s_axi_rvalid_out) begin
        v = s_axi_rdata_out;
        rs = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
        return;
      end
    end
    fails++;
    wrap_up();
  endtask : rd

  // program a mapping and compare status word and rate port
  task automatic map(input int f, input int n, input logic [31:0] c);
    logic [31:0] v;
    logic [1:0] rs;
    logic [31:0] e;
    wr(DTEMAP_A_SLOT, {19'h0, n[4:0], 3'h0, f[4:0]});
    wr(DTEMAP_A_CTRL, c);
    repeat (4) @(posedge clk_in);
    rd(DTEMAP_A_STAT, v, rs);
    e = stat_exp(f, n, c);
    check(v, e);
    check({15'h0, port_rate_kbps_out}, {16'h0, e[15:0]});
  endtask : map

  // main sequence
  initial begin
    seed = 16'h002c;
    resetn_in = 1'b0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = 4'h0;
    {s_axi_rready_in, rts_in, remote_cmd_in} = 3'h0;
    {v54_loop_in, prbs511_test_in, self_test_in, network_test_in} = 4'h0;
    {network_alarm_in, network_signal_ok_in} = 2'h0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
    s_axi_wstrb_in = 4'hf;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(DTEMAP_A_CTRL, d, r);
    check(d, DTEMAP_CTRL_RST);
    rd(DTEMAP_A_SLOT, d, r);
    check(d, DTEMAP_SLOT_RST);
    rd(8'h10, d, r);
    check(d, 32'h0);
    check({30'h0, r}, {30'h0, DTEMAP_RESP_ERR});
    for (i = 0; i < 8; i++) map(tf[i], tn[i], tc[i]);
    for (i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      map(seed % 24 + 1, (seed >> 5) % 24 + 1, {23'h0, seed[10], 6'h0, seed[12:11]});
    end
    for (i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      if (i % 4 == 0) fv = seed[15:13];
      if (i % 4 == 0) wr(DTEMAP_A_CTRL, {24'h0, fv, seed[12], i[3:2], 2'b01});
      cv = {seed[6], 5'h01 << seed[9:7], seed[0]};
      {rts_in, v54_loop_in, prbs511_test_in, self_test_in} <= cv[6:3];
      {network_test_in, network_alarm_in, network_signal_ok_in} <= cv[2:0];
      repeat (6) @(posedge clk_in);
      check({dsr_out, dcd_out, cts_out}, ctl_exp(cv, fv));
    end
    wr(DTEMAP_A_CTRL, 32'h0000_0201);
    remote_cmd_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    remote_cmd_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    check({31'h0, inband_open_out}, 32'h1);
    repeat (IDLE - 30) @(posedge clk_in);
    check({31'h0, inband_open_out}, 32'h1);
    repeat (40) @(posedge clk_in);
    check({31'h0, inband_open_out}, 32'h0);
    wr(DTEMAP_A_MGMT, {16'h0, seed});
    rd(DTEMAP_A_MGMT, d, r);
    check(d, {16'h0, seed});
    wrap_up();
  end
endmodule : dtemap_top_test

bind dtemap_top dtemap_assertions u_chk (.*);
`default_nettype wire
